/* src/clock_gate_bank_pkg.sv */
package clock_gate_bank_pkg;

	// ========================================================
	// Register map (byte addresses)
	// ========================================================
	localparam logic [11:0] RUN_GATE_OFFSET   = 12'h100;
	localparam logic [11:0] SLEEP_GATE_OFFSET = 12'h110;
	localparam logic [11:0] DEEP_GATE_OFFSET  = 12'h120;
	localparam logic [11:0] CLOCK_CFG_OFFSET  = 12'h130;
	localparam logic [11:0] POWER_MODE_OFFSET = 12'h134;
	localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h138;
	localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h13C;

	// ========================================================
	// Gate word layout
	// ========================================================
	localparam int WDOG_B_BIT    = 28;
	localparam int BUSCTL_B_BIT  = 25;
	localparam int BUSCTL_A_BIT  = 24;
	localparam int CONV_B_BIT    = 17;
	localparam int CONV_A_BIT    = 16;
	localparam int RATE_B_LSB    = 10;
	localparam int RATE_A_LSB    = 8;
	localparam int HIB_BIT       = 6;
	localparam int WDOG_A_BIT    = 3;
	localparam int NUM_UNITS     = 7;

	// Writable bits: 28, 25:24, 17:16, 11:8, 6, 3
	localparam logic [31:0] GATE_WRITE_MASK = 32'h1303_0F48;
	localparam logic [31:0] LOW_POWER_RESET = 32'h0000_0040;
	localparam logic [31:0] RUN_RESET       = 32'h0000_0000;
	localparam logic [1:0]  RATE_ONE_MSPS   = 2'h3;

	// Clock config and interrupt layout
	localparam int AUTO_GATE_BIT = 0;
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_MODE_BIT  = 1;
	localparam logic [31:0] IRQ_WRITE_MASK = 32'h0000_0003;

	// Power mode encoding on the mode register and the input
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_DEEP  = 3'b100
	} power_mode_e;

	// AHB transfer types
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;

endpackage

/* src/clock_gate_bank.sv */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Operation
// - Gate bit set in the active register keeps that unit clocked.
// - Gate bit clear stops unit clock; accesses to it get a bus fault.
// - Deep-sleep register chooses clocked units while in Deep-Sleep.
// - Run, sleep and deep-sleep gate registers share one layout.
// - Low-power registers act only when auto gating select is set.
// - Gate bits reset to zero unless another reset value is given.
// - Sleep and deep-sleep registers reset to word 0x00000040.
// - Bit 28 gates the second watchdog.
// - Bits 25 and 24 gate the second and first bus controllers.
// - Bits 17 and 16 gate the second and first converters.
// - Bit 6 gates the hibernation unit.
// - Bit 3 gates the first watchdog.
// - Bits 11:10 give second converter rate; code 3 is one MSPS.
// - Bits 9:8 give first converter rate, same encoding.
// - Reserved bits read zero; software preserves them.
module clock_gate_bank
	import clock_gate_bank_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [11:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Power mode request from the power controller
	input  wire logic [2:0]           power_mode_in,
	// Peripheral access attempts (one bit per unit, gate order)
	input  wire logic [NUM_UNITS-1:0] unit_access,
	// Gated clock enables, bus faults and sample rates
	output logic      [NUM_UNITS-1:0] unit_clk_en,
	output logic      [NUM_UNITS-1:0] unit_bus_fault,
	output logic      [1:0]           converter_a_sample_rate,
	output logic      [1:0]           converter_b_sample_rate,
	// Interrupt
	output logic                      irq
);

	// ========================================================
	// Helpers
	// ========================================================
	// Pick the seven gate bits out of a gate word, fixed order
	function automatic logic [NUM_UNITS-1:0] gate_bits(
		input logic [31:0] w
	);
		gate_bits = {w[WDOG_B_BIT], w[BUSCTL_B_BIT], w[BUSCTL_A_BIT],
			w[CONV_B_BIT], w[CONV_A_BIT], w[HIB_BIT], w[WDOG_A_BIT]};
	endfunction

	// Masked update of a writable register
	function automatic logic [31:0] masked_write(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [31:0] mask
	);
		masked_write = (old_v & ~mask) | (new_v & mask);
	endfunction

	// ========================================================
	// Registers
	// ========================================================
	logic [31:0]          run_gate_q;
	logic [31:0]          sleep_gate_q;
	logic [31:0]          deep_gate_q;
	logic                 auto_gate_q;
	logic [2:0]           mode_q;
	logic [1:0]           irq_status_q;
	logic [1:0]           irq_mask_q;
	logic [2:0]           mode_sync1_q;
	logic [2:0]           mode_sync2_q;
	logic [NUM_UNITS-1:0] acc_sync1_q;
	logic [NUM_UNITS-1:0] acc_sync2_q;
	logic                 wr_pend_q;
	logic [11:0]          addr_q;
	logic [31:0]          hrdata_q;
	logic [NUM_UNITS-1:0] clk_en_q;
	logic [NUM_UNITS-1:0] fault_q;
	logic [1:0]           rate_a_q;
	logic [1:0]           rate_b_q;
	logic                 irq_q;

	// ========================================================
	// Bus decode
	// ========================================================
	// Address phase taken when selected and the bus is ready
	wire logic addr_valid = hsel && hready &&
		(htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	wire logic do_write   = addr_valid && hwrite;
	wire logic do_read    = addr_valid && !hwrite;

	// Write strobes, applied in the data phase
	wire logic wr_run   = wr_pend_q && addr_q == RUN_GATE_OFFSET;
	wire logic wr_sleep = wr_pend_q && addr_q == SLEEP_GATE_OFFSET;
	wire logic wr_deep  = wr_pend_q && addr_q == DEEP_GATE_OFFSET;
	wire logic wr_cfg   = wr_pend_q && addr_q == CLOCK_CFG_OFFSET;
	wire logic wr_mask  = wr_pend_q && addr_q == IRQ_MASK_OFFSET;
	// Status is read-to-clear; the read is taken in the address phase
	wire logic rd_stat  = do_read && haddr == IRQ_STATUS_OFFSET;

	// Read mux; unmapped and reserved bits read zero
	logic [31:0] rd_mux;
	assign rd_mux =
		(haddr == RUN_GATE_OFFSET)   ? run_gate_q :
		(haddr == SLEEP_GATE_OFFSET) ? sleep_gate_q :
		(haddr == DEEP_GATE_OFFSET)  ? deep_gate_q :
		(haddr == CLOCK_CFG_OFFSET)  ? {31'h0, auto_gate_q} :
		(haddr == POWER_MODE_OFFSET) ? {29'h0, mode_q} :
		(haddr == IRQ_STATUS_OFFSET) ? {30'h0, irq_status_q} :
		(haddr == IRQ_MASK_OFFSET)   ? {30'h0, irq_mask_q} :
		32'h0000_0000;

	// ========================================================
	// Gate selection
	// ========================================================
	// low-power words only with auto gating
	wire logic use_low = auto_gate_q;
	// run word when auto gating is off
	wire logic [31:0] active_word =
		(use_low && mode_q == MODE_DEEP)  ? deep_gate_q :
		(use_low && mode_q == MODE_SLEEP) ? sleep_gate_q :
		run_gate_q;
	wire logic [NUM_UNITS-1:0] active_gates = gate_bits(active_word);
	// fault on access to gated unit
	wire logic [NUM_UNITS-1:0] fault_now = acc_sync2_q & ~active_gates;
	wire logic fault_event = |fault_now;
	wire logic mode_event  = mode_sync2_q != mode_q;
	wire logic mode_legal  = mode_sync2_q == MODE_RUN ||
		mode_sync2_q == MODE_SLEEP || mode_sync2_q == MODE_DEEP;

	// Sticky events; a new event wins over the read clear
	logic [1:0] ev_vec;
	assign ev_vec[IRQ_FAULT_BIT] = fault_event;
	assign ev_vec[IRQ_MODE_BIT]  = mode_event && mode_legal;
	wire logic [1:0] stat_d =
		(rd_stat ? 2'b00 : irq_status_q) | ev_vec;

	// ========================================================
	// Next values
	// ========================================================
	// Every register fed from these next values loads on each clock, no enables
	// Gate words take the masked write at the end of the data phase
	logic [31:0] run_gate_d;
	logic [31:0] sleep_gate_d;
	logic [31:0] deep_gate_d;
	logic [31:0] mask_word;
	logic        auto_gate_d;
	logic [2:0]  mode_d;
	logic [1:0]  irq_mask_d;
	logic        irq_d;

	assign run_gate_d   = wr_run ?
		masked_write(run_gate_q, hwdata, GATE_WRITE_MASK) : run_gate_q;
	assign sleep_gate_d = wr_sleep ?
		masked_write(sleep_gate_q, hwdata, GATE_WRITE_MASK) : sleep_gate_q;
	assign deep_gate_d  = wr_deep ?
		masked_write(deep_gate_q, hwdata, GATE_WRITE_MASK) : deep_gate_q;

	// Only the selector bit of the config word is kept
	assign auto_gate_d = wr_cfg ? hwdata[AUTO_GATE_BIT] : auto_gate_q;
	// Illegal codes ignored; a runt code while one-hot bits skew
	// through the synchroniser must not end the current mode
	assign mode_d = mode_legal ? mode_sync2_q : mode_q;

	// Mask word shares the status layout
	assign mask_word  = masked_write({30'h0, irq_mask_q}, hwdata,
		IRQ_WRITE_MASK);
	assign irq_mask_d = wr_mask ? mask_word[1:0] : irq_mask_q;
	// From the next status, so a read clear drops the pin at once
	assign irq_d      = |(stat_d & irq_mask_q);

	// ========================================================
	// Input synchronisers
	// ========================================================
	// Mode request comes from the power controller's domain
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_sync1_q <= MODE_RUN;
			mode_sync2_q <= MODE_RUN;
		end else begin
			mode_sync1_q <= power_mode_in;
			mode_sync2_q <= mode_sync1_q;
		end
	end

	// Access strobes are async; only the second stage is decoded
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_sync1_q <= '0;
			acc_sync2_q <= '0;
		end else begin
			acc_sync1_q <= unit_access;
			acc_sync2_q <= acc_sync1_q;
		end
	end

	// ========================================================
	// Bus pipeline
	// ========================================================
	// Zero-wait slave: a write is held over into its data phase
	// Transfer size is not decoded; only whole words are offered
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= do_write;
		end
	end

	// Address kept for the write strobes of the data phase
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			addr_q <= '0;
		end else if (addr_valid) begin
			addr_q <= haddr;
		end
	end

	// Read data stands from its data phase until the next read,
	// so a read-to-clear value cannot change under the master
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hrdata_q <= '0;
		end else if (do_read) begin
			hrdata_q <= rd_mux;
		end
	end

	// ========================================================
	// Gate registers
	// ========================================================
	// run gates reset zero
	// Every unit starts unclocked until software enables it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_gate_q <= RUN_RESET;
		end else begin
			run_gate_q <= run_gate_d;
		end
	end

	// sleep word 0x40
	// Hibernate stays clocked in Sleep once auto gating is set
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_gate_q <= LOW_POWER_RESET;
		end else begin
			sleep_gate_q <= sleep_gate_d;
		end
	end

	// deep-sleep word 0x40
	// Same reset word as Sleep, hibernate kept alive once auto gating is set
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			deep_gate_q <= LOW_POWER_RESET;
		end else begin
			deep_gate_q <= deep_gate_d;
		end
	end

	// ========================================================
	// Config, mode and interrupt registers
	// ========================================================
	// Auto gating off, so run gates rule until software opts in
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			auto_gate_q <= 1'b0;
		end else begin
			auto_gate_q <= auto_gate_d;
		end
	end

	// Effective mode; run out of reset
	// Lags the pin by three edges, the price of safe crossing
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_q <= MODE_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Sticky status; an event wins over the read clear
	// Hardware sets, a read of the status word clears
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= stat_d;
		end
	end

	// Interrupt mask; all sources masked out of reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_mask_q <= '0;
		end else begin
			irq_mask_q <= irq_mask_d;
		end
	end

	// ========================================================
	// Outputs
	// ========================================================
	// clock while gate set
	// Registered so a unit never sees a runt enable
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			clk_en_q <= '0;
		end else begin
			clk_en_q <= active_gates;
		end
	end

	// fault per access
	// Level for every cycle an access meets a gated unit
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fault_q <= '0;
		end else begin
			fault_q <= fault_now;
		end
	end

	// first and second converter rates
	// Codes pass through; keeping them legal is software's job
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rate_a_q <= '0;
			rate_b_q <= '0;
		end else begin
			rate_b_q <= active_word[RATE_B_LSB +: 2];
			rate_a_q <= active_word[RATE_A_LSB +: 2];
		end
	end

	// Level interrupt, updated on the same edge as the status
	// A mask write shows on the pin one cycle after it lands
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Bus answers at once and never faults
	assign hrdata                  = hrdata_q;
	assign hreadyout               = 1'b1;
	assign hresp                   = 1'b0;
	assign unit_clk_en             = clk_en_q;
	assign unit_bus_fault          = fault_q;
	assign converter_a_sample_rate = rate_a_q;
	assign converter_b_sample_rate = rate_b_q;
	assign irq                     = irq_q;

endmodule

/* verification/clock_gate_bank_checker.sv */
`timescale 1ns/1ps
module clock_gate_bank_checker
	import clock_gate_bank_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Bus side
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Unit side
	input wire logic [6:0]  unit_access,
	input wire logic [6:0]  unit_clk_en,
	input wire logic [6:0]  unit_bus_fault,
	input wire logic        irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// ========================================
	// Taken transfers, split by kind
	wire taken   = hsel && hready && htrans[1];
	wire rd_take = taken && !hwrite;
	wire gate_rd = rd_take && (haddr == RUN_GATE_OFFSET
		|| haddr == SLEEP_GATE_OFFSET || haddr == DEEP_GATE_OFFSET);

	// ========================================
	// Properties
	property p_ready_ok; hreadyout && !hresp; endproperty
	a_ready_ok: assert property (p_ready_ok)
		else $error("bus wait or error seen");
	property p_rst_out; $past(sys_rst) |-> !irq && unit_clk_en == '0
		&& unit_bus_fault == '0; endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not idle after reset");
	// Sync takes two edges, the fault flop a third
	property p_fault_src; (unit_bus_fault & ~$past(unit_access, 3)) == '0;
	endproperty
	a_fault_src: assert property (p_fault_src)
		else $error("fault without an access");
	property p_gate_resv; gate_rd |=> (hrdata & ~GATE_WRITE_MASK) == '0;
	endproperty
	a_gate_resv: assert property (p_gate_resv)
		else $error("reserved gate bits read nonzero");
	property p_unmapped; rd_take && haddr > IRQ_MASK_OFFSET |=> hrdata == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read nonzero");
	property p_rd_hold; !rd_take |=> $stable(hrdata); endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without a read");
	// Status read clears at once, a mask write lands later
	property p_irq_fall; $fell(irq) |-> $past(taken) || $past(taken, 2)
		|| $past(taken, 3); endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt dropped without software");
	property p_mode_hot; rd_take && haddr == POWER_MODE_OFFSET
		|=> $onehot(hrdata); endproperty
	a_mode_hot: assert property (p_mode_hot)
		else $error("mode readback not one-hot");

	// Main scenarios reached
	c_gate_rd: cover property (gate_rd);
	c_fault: cover property (|unit_bus_fault);
	c_irq: cover property ($rose(irq));
endmodule

bind clock_gate_bank clock_gate_bank_checker clock_gate_bank_checker_i (
	.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .unit_access, .unit_clk_en,
	.unit_bus_fault, .irq);

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import clock_gate_bank_pkg::*;
;
	// ========================================
	// Stimulus and bookkeeping
	logic        core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	logic [11:0] haddr = '0;
	logic [1:0]  htrans = '0, rate_a, rate_b;
	logic [2:0]  power_mode_in = MODE_RUN;
	logic [31:0] hwdata = '0, hrdata, seed = 32'h2aa2;
	logic [6:0]  unit_access = '0, unit_clk_en, unit_bus_fault;
	logic        hready, hresp, irq, rd_ph = 0, st_ph = 0, flt_ph = 0;
	int          num_errors = 0, checks = 0;
	logic [31:0] rd_q[$];
	logic [11:0] st_q[$];
	logic [6:0]  flt_q[$];
	int          bits[7] = '{WDOG_A_BIT, HIB_BIT, CONV_A_BIT, CONV_B_BIT,
		BUSCTL_A_BIT, BUSCTL_B_BIT, WDOG_B_BIT};

	always #12.5 core_clk = ~core_clk;

	clock_gate_bank clock_gate_bank_i (.core_clk, .sys_rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
		.hreadyout(hready), .hresp, .power_mode_in, .unit_access,
		.unit_clk_en, .unit_bus_fault, .converter_a_sample_rate(rate_a),
		.converter_b_sample_rate(rate_b), .irq);

	// ========================================
	// Tasks
	task automatic compare(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One compare per kind of result, widths kept exact
	task automatic compare_rd(input logic [31:0] got, exp);
		compare(got, exp);
	endtask
	task automatic compare_st(input logic [11:0] got, exp);
		compare({20'h0, got}, {20'h0, exp});
	endtask
	task automatic compare_flt(input logic [6:0] got, exp);
		compare({25'h0, got}, {25'h0, exp});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		hwrite <= w;
		haddr  <= a;
		htrans <= HTRANS_NONSEQ;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, $random(seed));
	endtask
	// Leaves room for the mode sync and the output register
	task automatic chk_state(input logic [11:0] e);
		repeat (6) @(posedge core_clk);
		st_q.push_back(e);
		st_ph <= 1'b1;
		@(posedge core_clk);
		st_ph <= 1'b0;
	endtask

	// Fault level is sampled while the access still stands
	task automatic chk_fault(input logic [6:0] e);
		repeat (6) @(posedge core_clk);
		flt_q.push_back(e);
		flt_ph <= 1'b1;
		@(posedge core_clk);
		flt_ph <= 1'b0;
	endtask

	// Result watcher: oldest note against each result
	always @(posedge core_clk) begin
		if (rd_ph)
			compare_rd(hrdata, rd_q.pop_front());
		if (st_ph)
			compare_st({irq, rate_b, rate_a, unit_clk_en},
				st_q.pop_front());
		if (flt_ph)
			compare_flt(unit_bus_fault, flt_q.pop_front());
		rd_ph <= hsel && hready && htrans[1] && !hwrite;
	end

	// ========================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [6:0]  a;
		logic [1:0]  rb, ra;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(SLEEP_GATE_OFFSET, 32'h0000_0040);
		rd(DEEP_GATE_OFFSET, 32'h0000_0040);
		rd(RUN_GATE_OFFSET, 32'h0000_0000);
		chk_state(12'h000);
		bus(1'b1, SLEEP_GATE_OFFSET, 32'hFFFF_FFFF);
		rd(SLEEP_GATE_OFFSET, 32'h1303_0F48);
		d = $random(seed) | 32'h0000_0F00;
		bus(1'b1, DEEP_GATE_OFFSET, d);
		rd(DEEP_GATE_OFFSET, d & 32'h1303_0F48);
		bus(1'b1, 12'h200, 32'hFFFF_FFFF);
		rd(12'h200, 32'h0000_0000);
		$display("test register_map done");
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, RUN_GATE_OFFSET, 32'h1 << bits[i]);
			chk_state(12'h1 << i);
		end
		for (int c = 0; c < 4; c++) begin
			rb = c[0] ? 2'h0 : RATE_ONE_MSPS;
			ra = c[1] ? 2'h0 : RATE_ONE_MSPS;
			bus(1'b1, RUN_GATE_OFFSET, {20'h0, rb, ra, 8'h0});
			chk_state({1'b0, rb, ra, 7'h0});
		end
		$display("test gates_and_rates done");
		bus(1'b1, RUN_GATE_OFFSET, 32'h1303_0048);
		bus(1'b1, SLEEP_GATE_OFFSET, 32'h0001_0000);
		bus(1'b1, DEEP_GATE_OFFSET, 32'h1000_0C00);
		power_mode_in <= MODE_SLEEP;
		chk_state(12'h07F);
		bus(1'b1, CLOCK_CFG_OFFSET, 32'h0000_0001);
		chk_state(12'h004);
		power_mode_in <= MODE_DEEP;
		chk_state(12'h640);
		rd(POWER_MODE_OFFSET, 32'h0000_0004);
		power_mode_in <= MODE_RUN;
		chk_state(12'h07F);
		$display("test power_modes done");
		rd(IRQ_STATUS_OFFSET, 32'h0000_0002);
		bus(1'b1, IRQ_MASK_OFFSET, 32'h0000_0001);
		bus(1'b1, RUN_GATE_OFFSET, 32'h0000_0000);
		a = 7'($random(seed)) | 7'h01;
		unit_access <= a;
		chk_fault(a);
		chk_state(12'h800);
		unit_access <= '0;
		repeat (4) @(posedge core_clk);
		rd(IRQ_STATUS_OFFSET, 32'h0000_0001);
		chk_state(12'h000);
		bus(1'b1, IRQ_MASK_OFFSET, 32'h0000_0000);
		bus(1'b1, RUN_GATE_OFFSET, 32'h1303_0008);
		unit_access <= 7'h7F;
		chk_fault(7'h02);
		chk_state(12'h07D);
		unit_access <= '0;
		repeat (4) @(posedge core_clk);
		rd(IRQ_STATUS_OFFSET, 32'h0000_0001);
		$display("test faults_and_irq done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(SLEEP_GATE_OFFSET, 32'h0000_0040);
		chk_state(12'h000);
		$display("test mid_run_reset done");
		summarize();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
endmodule
